// ---- tb/comparator_signal_conditioner_bench.sv ----
// Self-checking bench of the comparator signal conditioner.
// Assumes the design answers on AXI4-Lite within 200 cycles.
`timescale 1ns/1ps

module comparator_signal_conditioner_bench import csc_pkg::*;;
    // ********************************************************
    // Signals
    // ********************************************************
    logic clk, sys_rst, clkEn;
    logic [1:0] cmpWant, cmpRaw, motorPwmFault, cmpFiltered, pol, ef;
    logic [3:0] pwmWant, pwmGate, pwm;
    logic irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] win;
    logic [33:0] rExp;
    logic [1:0] wq [$];  // Expected write responses
    logic [33:0] rq [$]; // Expected read data and response
    logic [4:0] adr [5] = '{ADDR_IRQ_ENABLE, ADDR_IRQ_FLAGS, ADDR_CLK_CTRL,
        ADDR_CONFIG, ADDR_WINDOW};
    logic [31:0] msk [5] = '{32'h3, 32'h0, 32'hFB, 32'hFF, 32'hFF};
    // Config, raw levels, expected filtered levels
    logic [11:0] tbl [5] = '{12'h00C, 12'h22F, 12'h333, 12'h33C, 12'h139};
    int errorCnt = 0;
    int testsRun = 0;
    int i, j, k, n, d, per, v;

    // ********************************************************
    // Design and far side
    // ********************************************************
    csc_top u_dut (.clk(clk), .clkEn(clkEn), .sys_rst(sys_rst),
        .cmpRaw(cmpRaw), .pwm_high_side_gate(pwmGate),
        .motorPwmFault(motorPwmFault), .cmpFiltered(cmpFiltered), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    csc_far_model u_far (.clk(clk), .cmpWant(cmpWant), .pwmWant(pwmWant),
        .cmpRaw(cmpRaw), .pwmGate(pwmGate));

    // ********************************************************
    // Tasks
    // ********************************************************
    // Verdict and end of run
    task automatic tallyAndFinish();
        if (errorCnt == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Count a hang as a mismatch and stop
    task automatic fail();
        errorCnt++;
        tallyAndFinish();
    endtask

    // One comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Let a number of edges pass
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask

    // AXI4-Lite write, expected response noted for the monitor
    task automatic axiWr(input logic [4:0] a, input logic [31:0] dat,
            input logic [1:0] r);
        int c;
        logic awOk, wOk, bOk;
        wq.push_back(r);
        c = 0;
        awOk = 0;
        wOk = 0;
        bOk = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bOk) begin
            @(posedge clk);
            c++;
            if (c > 200) fail();
            if (s_axi_awready && !awOk) begin
                s_axi_awvalid <= 1'b0;
                awOk = 1;
            end
            if (s_axi_wready && !wOk) begin
                s_axi_wvalid <= 1'b0;
                wOk = 1;
            end
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                bOk = 1;
            end
        end
    endtask

    // AXI4-Lite read, expected data and response noted for the monitor
    task automatic axiRd(input logic [4:0] a, input logic [31:0] dat,
            input logic [1:0] r);
        int c;
        logic rOk;
        rq.push_back({dat, r});
        c = 0;
        rOk = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rOk) begin
            @(posedge clk);
            c++;
            if (c > 200) fail();
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                rOk = 1;
            end
        end
    endtask

    // Wait, bounded, for a filtered level; returns the cycles taken
    task automatic waitFilt(input int c, input logic lv, input int lim,
            output int cnt);
        cnt = 0;
        while (cmpFiltered[c] !== lv) begin
            @(posedge clk);
            cnt++;
            if (cnt > lim) fail();
        end
    endtask

    // ********************************************************
    // Clock and response monitor
    // ********************************************************
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    // Takes the oldest note off a queue whenever a response appears
    always @(posedge clk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            chk({30'h0, s_axi_bresp}, {30'h0, wq.pop_front()});
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rExp = rq.pop_front();
            chk(s_axi_rdata, rExp[33:2]);
            chk({30'h0, s_axi_rresp}, {30'h0, rExp[1:0]});
        end
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        void'($urandom(32'hB6BD33D5));
        sys_rst = 1;
        {cmpWant, pwmWant, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        clkEn = 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        // Reset values, masked read-back, unmapped place
        for (i = 0; i < 5; i++) axiRd(adr[i], 32'h0, RESP_OKAY);
        for (i = 0; i < 5; i++) axiWr(adr[i], 32'hFFFFFFFF, RESP_OKAY);
        for (i = 0; i < 5; i++) axiRd(adr[i], msk[i], RESP_OKAY);
        axiWr(5'h14, 32'hFFFFFFFF, RESP_SLVERR);
        axiRd(5'h14, 32'h0, RESP_SLVERR);
        // Second reset in mid-run
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        axiRd(ADDR_CONFIG, 32'h0, RESP_OKAY);
        // Filter delay for every prescaler, random divider but field 15 at prescaler 8
        axiWr(ADDR_CONFIG, 32'h02, RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            d = (i == 3) ? 15 : $urandom_range(15, 0);
            per = (1 << i) * (d + 1);
            axiWr(ADDR_CLK_CTRL, 32'(d * 16 + 8 + i), RESP_OKAY);
            for (v = 1; v >= 0; v--) begin
                cmpWant[0] <= v[0];
                waitFilt(0, v[0], 17 * per + 8, n);
                chk(32'(n >= 16 * per + 1), 32'h1);
            end
        end
        // Pulses of sixteen and seventeen filter ticks
        axiWr(ADDR_CLK_CTRL, 32'h08, RESP_OKAY);
        cmpWant[0] <= 1'b1;
        cyc(16);
        cmpWant[0] <= 1'b0;
        cyc(40);
        chk({30'h0, cmpFiltered}, 32'h0);
        cmpWant[0] <= 1'b1;
        cyc(17);
        cmpWant[0] <= 1'b0;
        waitFilt(0, 1'b1, 30, n);
        waitFilt(0, 1'b0, 30, n);
        // No filter clock while the enable bit is clear
        axiWr(ADDR_CLK_CTRL, 32'h00, RESP_OKAY);
        cmpWant[0] <= 1'b1;
        cyc(200);
        chk({30'h0, cmpFiltered}, 32'h0);
        axiWr(ADDR_CLK_CTRL, 32'h08, RESP_OKAY);
        waitFilt(0, 1'b1, 30, n);
        // Clock enable low freezes the filter and its synchronisers
        clkEn <= 1'b0;
        cmpWant[0] <= 1'b0;
        cyc(40);
        chk({30'h0, cmpFiltered}, 32'h1);
        clkEn <= 1'b1;
        waitFilt(0, 1'b0, 30, n);
        // Input enable and polarity on both comparators
        for (k = 0; k < 5; k++) begin
            axiWr(ADDR_CONFIG, {24'h0, tbl[k][11:4]}, RESP_OKAY);
            cmpWant <= tbl[k][3:2];
            cyc(40);
            chk({30'h0, cmpFiltered}, {30'h0, tbl[k][1:0]});
        end
        // Interrupts: A edge, B level, window closed meanwhile
        axiWr(ADDR_WINDOW, 32'h11, RESP_OKAY);
        pwmWant <= 4'h1;
        cmpWant <= 2'b00;
        axiWr(ADDR_CONFIG, 32'h26, RESP_OKAY);
        cyc(40);
        axiWr(ADDR_IRQ_FLAGS, 32'h3, RESP_OKAY);
        axiRd(ADDR_IRQ_FLAGS, 32'h0, RESP_OKAY);
        cmpWant <= 2'b11;
        cyc(40);
        chk({30'h0, motorPwmFault}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        axiRd(ADDR_IRQ_FLAGS, 32'h3, RESP_OKAY);
        axiWr(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
        cyc(3);
        chk({31'h0, irq}, 32'h1);
        axiWr(ADDR_IRQ_FLAGS, 32'h3, RESP_OKAY);
        axiRd(ADDR_IRQ_FLAGS, 32'h2, RESP_OKAY);
        cyc(3);
        chk({31'h0, irq}, 32'h0);
        axiWr(ADDR_IRQ_ENABLE, 32'h2, RESP_OKAY);
        cyc(3);
        chk({31'h0, irq}, 32'h1);
        axiWr(ADDR_IRQ_FLAGS, 32'h0, RESP_OKAY);
        axiRd(ADDR_IRQ_FLAGS, 32'h2, RESP_OKAY);
        // Random windows, gates and window polarities
        for (k = 0; k < 12; k++) begin
            win = (k == 0) ? 8'h00 : 8'($urandom);
            pol = 2'($urandom);
            pwm = 4'($urandom);
            pwmWant <= pwm;
            axiWr(ADDR_WINDOW, {24'h0, win}, RESP_OKAY);
            axiWr(ADDR_CONFIG, {24'h0, pol[1], 3'h2, pol[0], 3'h6}, RESP_OKAY);
            cyc(6);
            for (j = 0; j < 2; j++) begin
                ef[j] = (win[j*4+:4] == 4'h0) ||
                    (|(win[j*4+:4] & (pol[j] ? pwm : ~pwm)));
            end
            chk({30'h0, motorPwmFault}, {30'h0, ef});
        end
        tallyAndFinish();
    end
endmodule

// ---- tb/csc_far_model.sv ----
// Far side of the conditioner: two analog comparators and four PWM
// high-side gates. Assumes the bench sets wanted levels after clk rises.
`timescale 1ns/1ps

module csc_far_model (
    // Bench clock
    input wire logic clk,
    // Levels the bench asks for
    input wire logic [1:0] cmpWant,
    input wire logic [3:0] pwmWant,
    // Analog side outputs
    output logic [1:0] cmpRaw,
    output logic [3:0] pwmGate
);
    // ********************************************************
    // Level sources
    // ********************************************************
    // Known idle levels before the first edge
    initial begin
        cmpRaw = 2'h0;
        pwmGate = 4'h0;
    end

    // Outputs move 3 ns after the edge, like sources with no clock
    always @(posedge clk) begin
        cmpRaw <= #3 cmpWant;
        pwmGate <= #3 pwmWant;
    end
endmodule

// ---- verilog/csc_pkg.sv ----
// Package for the comparator signal conditioner.
// Assumes a single main clock and a 32-bit AXI4-Lite register bus.
package csc_pkg;

    // ********************************************************
    // Register byte offsets
    // ********************************************************
    localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h00;
    localparam logic [4:0] ADDR_IRQ_FLAGS = 5'h04;
    localparam logic [4:0] ADDR_CLK_CTRL = 5'h08;
    localparam logic [4:0] ADDR_CONFIG = 5'h0C;
    localparam logic [4:0] ADDR_WINDOW = 5'h10;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CLK_DIV_LSB = 4;
    localparam int CLK_EN_BIT = 3;
    localparam int CFG_STRIDE = 4;
    localparam int CFG_POL = 0;
    localparam int CFG_INON = 1;
    localparam int CFG_TRIG = 2;
    localparam int CFG_WPOL = 3;
    localparam int NUM_CMP = 2;
    localparam int NUM_PWM = 4;

    // ********************************************************
    // Reset values, timing and answers
    // ********************************************************
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [4:0] FILTER_TICKS = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- verilog/csc_top.sv ----
// Comparator signal conditioner: sync, polarity, glitch filter,
// PWM windowing, interrupts and an AXI4-Lite register slave.
// Assumes comparator and PWM inputs are asynchronous to clk.
//
// Contract
// - Per-comparator interrupt enable, bits one and zero
// - Sticky flags, write one clears them
// - Bits 7:4 divide clock by value+1
// - Bits 1:0 power-of-two prescaler 1,2,4,8
// - Filter clock runs only when bit3 set
// - Rate is clk over prescale over divide
// - Output changes after more than sixteen ticks
// - Input enable bits five and one
// - Polarity bits four and zero invert input
// - Trigger type bits six and two
// - Window polarity bits seven and three
// - Window enable nibble per comparator
// - All-zero nibble means no gating
// - Interrupts ignore window gating
// - Windowed signals go to PWM fault
// - Five registers at 0x00 to 0x10
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps

module csc_top
    import csc_pkg::*;
(
    // Clock, enable and reset
    input wire logic clk,
    input wire logic clkEn,
    input wire logic sys_rst,
    // Analog comparator outputs and PWM high-side gates
    input wire logic [1:0] cmpRaw,
    input wire logic [3:0] pwm_high_side_gate,
    // Results
    output logic [1:0] motorPwmFault,
    output logic [1:0] cmpFiltered,
    output logic irq,
    // AXI4-Lite write address
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ********************************************************
    // Registers
    // ********************************************************
    logic [1:0] irqEn_ff;       // Interrupt enables
    logic [1:0] irqFlag_ff;     // Sticky flags
    logic [7:0] clkCtrl_ff;     // Divider, enable, prescaler
    logic [7:0] config_ff;      // Per-comparator config nibbles
    logic [7:0] window_ff;      // Window enable nibbles
    logic [1:0] sync1_ff;       // First synchroniser stage
    logic [1:0] sync2_ff;       // Second synchroniser stage
    logic [3:0] pwmSync1_ff;    // PWM first stage
    logic [3:0] pwmSync2_ff;    // PWM second stage
    logic [2:0] preCnt_ff;      // Prescaler counter
    logic [3:0] divCnt_ff;      // Linear divider counter
    logic tick_ff;              // One-cycle filter clock tick
    logic [1:0] prevAct_ff;     // Previous filtered level
    logic [4:0] stableCnt_ff [NUM_CMP];

    // AXI holding state
    logic awHeld_ff;
    logic wHeld_ff;
    logic [4:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;

    // Decoded fields
    logic [3:0] linDiv;
    logic [1:0] pow2Sel;
    logic [2:0] preMax;
    logic filterOn;
    logic wrFire;
    logic [1:0] irqEvent;
    logic [1:0] conditioned;

    assign linDiv = clkCtrl_ff[CLK_DIV_LSB +: 4];
    assign pow2Sel = clkCtrl_ff[1:0];
    assign filterOn = clkCtrl_ff[CLK_EN_BIT];
    assign wrFire = awHeld_ff && wHeld_ff && !s_axi_bvalid;

    // Prescaler terminal count: 2**sel minus one
    always_comb begin
        case (pow2Sel)
            2'h0: preMax = 3'h0;
            2'h1: preMax = 3'h1;
            2'h2: preMax = 3'h3;
            2'h3: preMax = 3'h7;
            default: preMax = 3'h0;
        endcase
    end

    // Register read mux, unused bits read zero
    function automatic logic [31:0] readReg(input logic [4:0] a,
        input logic [1:0] en, input logic [1:0] fl, input logic [7:0] ck,
        input logic [7:0] cf, input logic [7:0] wn);
        readReg = 32'h0000_0000;
        case (a)
            ADDR_IRQ_ENABLE: readReg[1:0] = en;
            ADDR_IRQ_FLAGS: readReg[1:0] = fl;
            ADDR_CLK_CTRL: readReg[7:0] = ck & 8'hFB;
            ADDR_CONFIG: readReg[7:0] = cf;
            ADDR_WINDOW: readReg[7:0] = wn;
            default: readReg = 32'h0000_0000;
        endcase
    endfunction

    // Valid offset check, shared by both directions
    function automatic logic mapped(input logic [4:0] a);
        mapped = (a == ADDR_IRQ_ENABLE) || (a == ADDR_IRQ_FLAGS) ||
            (a == ADDR_CLK_CTRL) || (a == ADDR_CONFIG) ||
            (a == ADDR_WINDOW);
    endfunction

    // ********************************************************
    // Input synchronisers
    // ********************************************************
    // Two flops per asynchronous input
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_ff <= 2'h0;
            sync2_ff <= 2'h0;
            pwmSync1_ff <= 4'h0;
            pwmSync2_ff <= 4'h0;
        end else if (clkEn) begin
            sync1_ff <= cmpRaw;
            sync2_ff <= sync1_ff;
            pwmSync1_ff <= pwm_high_side_gate;
            pwmSync2_ff <= pwmSync1_ff;
        end
    end

    // ********************************************************
    // Filter clock generation
    // ********************************************************
    // Prescaler then linear divider; tick marks a filter edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            preCnt_ff <= 3'h0;
            divCnt_ff <= 4'h0;
            tick_ff <= 1'b0;
        end else if (clkEn) begin
            tick_ff <= 1'b0;
            if (!filterOn) begin
                preCnt_ff <= 3'h0;
                divCnt_ff <= 4'h0;
            end else if (preCnt_ff >= preMax) begin
                preCnt_ff <= 3'h0;
                if (divCnt_ff >= linDiv) begin
                    divCnt_ff <= 4'h0;
                    tick_ff <= 1'b1;
                end else begin
                    divCnt_ff <= divCnt_ff + 4'h1;
                end
            end else begin
                preCnt_ff <= preCnt_ff + 3'h1;
            end
        end
    end

    // ********************************************************
    // Per-comparator conditioning and filter
    // ********************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : gCmp
            logic pol;
            logic inOn;
            logic trig;
            logic wPol;
            logic [3:0] wEn;
            logic gated;

            assign pol = config_ff[gi * CFG_STRIDE + CFG_POL];
            assign inOn = config_ff[gi * CFG_STRIDE + CFG_INON];
            assign trig = config_ff[gi * CFG_STRIDE + CFG_TRIG];
            assign wPol = config_ff[gi * CFG_STRIDE + CFG_WPOL];
            assign wEn = window_ff[gi * NUM_PWM +: NUM_PWM];
            // Gated off input reads inactive; polarity inverts
            assign conditioned[gi] = inOn && (sync2_ff[gi] ^ pol);
            // Window opens when any selected gate matches polarity
            assign gated = |(wEn & (wPol ? pwmSync2_ff : ~pwmSync2_ff));
            // Edge mode fires on rise, level mode while active
            assign irqEvent[gi] = trig ?
                (cmpFiltered[gi] && !prevAct_ff[gi]) : cmpFiltered[gi];

            // Count filter ticks the input differs from the output
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    stableCnt_ff[gi] <= 5'h00;
                    cmpFiltered[gi] <= 1'b0;
                end else if (clkEn) begin
                    if (conditioned[gi] == cmpFiltered[gi]) begin
                        stableCnt_ff[gi] <= 5'h00;
                    end else if (tick_ff) begin
                        if (stableCnt_ff[gi] >= FILTER_TICKS) begin
                            cmpFiltered[gi] <= conditioned[gi];
                            stableCnt_ff[gi] <= 5'h00;
                        end else begin
                            stableCnt_ff[gi] <= stableCnt_ff[gi] + 5'h01;
                        end
                    end
                end
            end

            // Windowed fault signal to the motor PWM unit
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    motorPwmFault[gi] <= 1'b0;
                end else if (clkEn) begin
                    if (wEn == 4'h0) begin
                        motorPwmFault[gi] <= cmpFiltered[gi];
                    end else begin
                        motorPwmFault[gi] <= cmpFiltered[gi] && gated;
                    end
                end
            end
        end
    endgenerate

    // Previous filtered level for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prevAct_ff <= 2'h0;
        end else if (clkEn) begin
            prevAct_ff <= cmpFiltered;
        end
    end

    // ********************************************************
    // Control registers
    // ********************************************************
    // Software writes, low byte lane only holds bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqEn_ff <= 2'h0;
            clkCtrl_ff <= REG_RESET;
            config_ff <= REG_RESET;
            window_ff <= REG_RESET;
        end else if (clkEn && wrFire && wStrb_ff[0]) begin
            case (awAddr_ff)
                ADDR_IRQ_ENABLE: irqEn_ff <= wData_ff[1:0];
                ADDR_CLK_CTRL: clkCtrl_ff <= wData_ff[7:0] & 8'hFB;
                ADDR_CONFIG: config_ff <= wData_ff[7:0];
                ADDR_WINDOW: window_ff <= wData_ff[7:0];
                default: irqEn_ff <= irqEn_ff;
            endcase
        end
    end

    // Sticky flags: hardware set wins over write-one clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqFlag_ff <= 2'h0;
        end else if (clkEn) begin
            if (wrFire && wStrb_ff[0] && awAddr_ff == ADDR_IRQ_FLAGS) begin
                irqFlag_ff <= (irqFlag_ff & ~wData_ff[1:0]) | irqEvent;
            end else begin
                irqFlag_ff <= irqFlag_ff | irqEvent;
            end
        end
    end

    // Interrupt line: any enabled flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else if (clkEn) begin
            irq <= |(irqFlag_ff & irqEn_ff);
        end
    end

    // ********************************************************
    // AXI4-Lite write channel
    // ********************************************************
    // Catch address and data in either order, then respond
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= 5'h00;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clkEn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !awHeld_ff && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
                awHeld_ff <= 1'b1;
            end
            if (s_axi_wvalid && !wHeld_ff && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
                wHeld_ff <= 1'b1;
            end
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
            end
        end
    end

    // ********************************************************
    // AXI4-Lite read channel
    // ********************************************************
    // One read at a time, answer in the same cycle as acceptance
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (clkEn) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= readReg(s_axi_araddr, irqEn_ff, irqFlag_ff,
                    clkCtrl_ff, config_ff, window_ff);
                s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || !clkEn);

    a_no_tick_off: assert property (
        !filterOn |=> !tick_ff)
        else $error("filter tick while clock disabled");
    a_div_one_tick: assert property (
        (filterOn && pow2Sel == 2'h0 && linDiv == 4'h0 && clkEn)[*2]
        |-> tick_ff)
        else $error("divide by one missed tick");
    a_filter_hold: assert property (
        $changed(cmpFiltered[0]) |-> $past(tick_ff))
        else $error("filtered output changed without tick");
    a_input_off: assert property (
        !config_ff[CFG_INON] && !cmpFiltered[0] |=> !cmpFiltered[0])
        else $error("disabled input passed");
    a_flag_sticky: assert property (
        irqFlag_ff[0] && !wrFire |=> irqFlag_ff[0])
        else $error("flag dropped without clear");
    a_irq_gate: assert property (
        !(|(irqFlag_ff & irqEn_ff)) |=> !irq)
        else $error("irq without enabled flag");
    a_fault_nowin: assert property (
        window_ff[3:0] == 4'h0 && $stable(window_ff) |=>
        motorPwmFault[0] == $past(cmpFiltered[0]))
        else $error("ungated fault mismatch");
    a_edge_flag: assert property (
        config_ff[CFG_TRIG] && cmpFiltered[0] && !prevAct_ff[0]
        |=> irqFlag_ff[0])
        else $error("edge did not set flag");
    a_read_resp: assert property (
        s_axi_arvalid && s_axi_arready |-> s_axi_rvalid)
        else $error("read answer missing");

    c_fault_gated: cover property (motorPwmFault[0] && window_ff != 8'h0);
    c_irq_high: cover property (irq);
    c_filter_change: cover property ($rose(cmpFiltered[1]));
    c_w1c: cover property (wrFire && awAddr_ff == ADDR_IRQ_FLAGS);

endmodule
